// *** verilog/daqio_pkg.sv ***
// Constants and types shared by the digital I/O, D/A and status register block
package daqio_pkg;

    // ------------------------------------------------------------
    // Host port geometry
    // ------------------------------------------------------------
    localparam int unsigned DAQIO_ADDR_W = 5;
    localparam int unsigned DAQIO_DATA_W = 8;
    localparam int unsigned DAQIO_DIO_W  = 16;
    localparam int unsigned DAQIO_DAC_W  = 12;
    localparam int unsigned DAQIO_CHAN_W = 4;
    localparam int unsigned DAQIO_LVL_W  = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [DAQIO_ADDR_W-1:0] DAQIO_OFF_DIO_LOW  = 5'h03;
    localparam logic [DAQIO_ADDR_W-1:0] DAQIO_OFF_DAC_LOW  = 5'h04;
    localparam logic [DAQIO_ADDR_W-1:0] DAQIO_OFF_DAC_HIGH = 5'h05;
    localparam logic [DAQIO_ADDR_W-1:0] DAQIO_OFF_FIFO_IRQ = 5'h06;
    localparam logic [DAQIO_ADDR_W-1:0] DAQIO_OFF_STATUS   = 5'h08;
    localparam logic [DAQIO_ADDR_W-1:0] DAQIO_OFF_DIO_HIGH = 5'h0B;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned DAQIO_FIFO_EN_BIT  = 0;
    localparam int unsigned DAQIO_WIDTH_BIT    = 7;
    localparam int unsigned DAQIO_DAC_LOW_MSB  = 7;
    localparam int unsigned DAQIO_DAC_LOW_LSB  = 4;
    localparam int unsigned DAQIO_DAC_LOW_W    = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DAQIO_DIO_W-1:0]  DAQIO_DOUT_RST = 16'h0000;
    localparam logic [DAQIO_DAC_W-1:0]  DAQIO_DAC_RST  = 12'h000;
    localparam logic [DAQIO_DATA_W-1:0] DAQIO_BYTE_RST = 8'h00;

    // ------------------------------------------------------------
    // Read answer state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        DAQIO_RD_IDLE   = 1'b0,
        DAQIO_RD_ANSWER = 1'b1
    } daqio_rd_e;

endpackage

// *** verilog/daqio_dac_if.sv ***
// Link between the register decoder and the D/A double buffer
`timescale 1ns/1ps
interface daqio_dac_if;
    import daqio_pkg::*;

    logic                    wr_low;     // Low byte write strobe
    logic                    wr_high;    // High byte write strobe
    logic [DAQIO_DATA_W-1:0] wdata;      // Host write byte
    logic [DAQIO_DAC_W-1:0]  dac_value;  // Value applied to converter

    modport regs (output wr_low, output wr_high, output wdata, input dac_value);
    modport dac  (input wr_low, input wr_high, input wdata, output dac_value);
endinterface

// *** verilog/daqio_dac.sv ***
// Double-buffered 12-bit D/A data holder
`timescale 1ns/1ps
module daqio_dac
    import daqio_pkg::*;
(
    input  wire logic core_clk,  // Card clock
    input  wire logic resetn,    // Async reset, active low
    input  wire logic ce,        // Clock enable
    daqio_dac_if.dac  bus        // Strobes and data from decoder
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DAQIO_DAC_LOW_W-1:0] low_hold;  // Held low nibble
        logic [DAQIO_DAC_W-1:0]     dac_out;   // Converter input
    } daqio_dac_s;

    daqio_dac_s st_ff;
    daqio_dac_s nxt_st;

    // Low write parks the nibble, high write commits the whole word
    always_comb begin
        nxt_st = st_ff;
        if (bus.wr_low) begin
            nxt_st.low_hold = bus.wdata[DAQIO_DAC_LOW_MSB:DAQIO_DAC_LOW_LSB];
        end
        if (bus.wr_high) begin
            // Single update, so the converter never sees a half-new word
            nxt_st.dac_out = {bus.wdata, st_ff.low_hold};
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{low_hold: '0, dac_out: DAQIO_DAC_RST};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign bus.dac_value = st_ff.dac_out;

endmodule

// *** verilog/daqio_regs.sv ***
// Digital I/O, D/A and A/D status registers of the acquisition card
//
// How it works
// - Reads of 03H and 0BH return input lines 0-7 and 8-15.
// - Input lines are sampled at each read, never latched; drive ends after.
// - Writes to 03H and 0BH load output lines 0-7 and 8-15.
// - Output latches hold until rewritten; reads at those offsets give inputs.
// - D/A value is 12 bits: low nibble from 04H bits 7-4, high from 05H.
// - Low D/A write only fills a holding register.
// - High D/A write moves high byte and held nibble to converter together.
// - Bit 0 at 06H enables the FIFO interrupt; bits 6-1 ignored.
// - Any write to 08H clears the pending conversion interrupt, unless a conversion finishes in the same cycle.
// - Status at 08H: busy, polarity, input setup, data valid, channel.
// - Write to status clears only data valid; other bits unchanged.
// - Busy reads 1 during conversion, 0 when idle and ready.
// - Polarity reads 0 for bipolar next channel, 1 for unipolar.
// - Input setup reads 0 for 8 differential, 1 for 16 single-ended.
// - Data valid sets when a conversion finishes, 0 until then.
// - Data valid with interrupt gate set raises the bus interrupt.
// - While idle, low status bits show the next channel number.
// - Interrupt gate at 0 keeps any interrupt off the host bus.
`timescale 1ns/1ps
module daqio_regs
    import daqio_pkg::*;
(
    input  wire logic                    core_clk,               // Card clock, 40 MHz
    input  wire logic                    resetn,                 // Async reset, active low
    input  wire logic                    ce,                     // Clock enable
    // Host I/O port
    input  wire logic [DAQIO_ADDR_W-1:0] io_addr,                // Byte offset
    input  wire logic                    io_wr,                  // Write strobe
    input  wire logic                    io_rd,                  // Read strobe
    input  wire logic [DAQIO_DATA_W-1:0] io_wdata,               // Write byte
    output logic      [DAQIO_DATA_W-1:0] io_rdata,               // Read byte
    output logic                         io_rdata_oe,            // Read data driven
    // Field digital lines
    input  wire logic [DAQIO_DIO_W-1:0]  input_port_bits,        // Input pins
    output logic      [DAQIO_DIO_W-1:0]  output_port_bits,       // Output pins
    // Converter side
    output logic      [DAQIO_DAC_W-1:0]  dac_value_bits,         // D/A word
    input  wire logic                    conv_start,             // Conversion begun
    input  wire logic                    conv_done,              // Result ready
    input  wire logic [DAQIO_CHAN_W-1:0] next_channel_number,    // Mux next channel
    input  wire logic                    next_chan_unipolar,     // Next range unipolar
    input  wire logic                    input_config_flag,      // Setup jumper pin
    // Neighbouring control register
    input  wire logic                    irq_gate,               // Interrupt gate bit
    input  wire logic [DAQIO_LVL_W-1:0]  irq_level_select,       // Interrupt level
    output logic                         fifo_irq_enable,        // FIFO interrupt on
    output logic                         converter_width_select, // Width select bit
    output logic                         irq_req,                // Interrupt request
    output logic      [DAQIO_LVL_W-1:0]  irq_level               // Level for irq_req
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DAQIO_DIO_W-1:0]  din_meta;   // First sync stage
        logic [DAQIO_DIO_W-1:0]  din_sync;   // Second sync stage
        logic                    cfg_meta;   // Jumper first stage
        logic                    cfg_sync;   // Jumper second stage
        logic [DAQIO_DIO_W-1:0]  dout;       // Output latches
        logic                    fifo_en;    // FIFO interrupt enable
        logic                    width_sel;  // Converter width select
        logic                    busy;       // Conversion in progress
        logic                    valid;      // Data valid flag
        logic [DAQIO_CHAN_W-1:0] chan;       // Reported channel
        logic                    irq;        // Interrupt output
        logic [DAQIO_LVL_W-1:0]  level;      // Interrupt level
        daqio_rd_e               rd_state;   // Read answer phase
        logic [DAQIO_DATA_W-1:0] rdata;      // Read answer byte
    } daqio_regs_s;

    daqio_regs_s st_ff;
    daqio_regs_s nxt_st;

    daqio_dac_if dac_link ();

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic                    wr_dio_low;
    logic                    wr_dio_high;
    logic                    wr_fifo;
    logic                    wr_status;
    logic                    rd_hit;
    logic [DAQIO_DATA_W-1:0] rd_byte;
    logic [DAQIO_DATA_W-1:0] status_byte;

    // Write strobes, one per documented offset
    assign wr_dio_low  = io_wr && (io_addr == DAQIO_OFF_DIO_LOW);
    assign wr_dio_high = io_wr && (io_addr == DAQIO_OFF_DIO_HIGH);
    assign wr_fifo     = io_wr && (io_addr == DAQIO_OFF_FIFO_IRQ);
    assign wr_status   = io_wr && (io_addr == DAQIO_OFF_STATUS);

    // D/A strobes go to the double buffer
    assign dac_link.wr_low  = io_wr && (io_addr == DAQIO_OFF_DAC_LOW);
    assign dac_link.wr_high = io_wr && (io_addr == DAQIO_OFF_DAC_HIGH);
    assign dac_link.wdata   = io_wdata;

    // Status layout, channel frozen by the state logic while busy
    assign status_byte = {st_ff.busy,
                          next_chan_unipolar,
                          st_ff.cfg_sync,
                          st_ff.valid,
                          st_ff.chan};

    // Read mux; the output latches are never a source here
    always_comb begin
        rd_hit  = 1'b0;
        rd_byte = DAQIO_BYTE_RST;
        case (io_addr)
            DAQIO_OFF_DIO_LOW: begin
                rd_hit  = 1'b1;
                rd_byte = st_ff.din_sync[DAQIO_DATA_W-1:0];
            end
            DAQIO_OFF_DIO_HIGH: begin
                rd_hit  = 1'b1;
                rd_byte = st_ff.din_sync[DAQIO_DIO_W-1:DAQIO_DATA_W];
            end
            DAQIO_OFF_STATUS: begin
                rd_hit  = 1'b1;
                rd_byte = status_byte;
            end
            default: begin
                rd_hit  = 1'b0;
                rd_byte = DAQIO_BYTE_RST;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Pins pass two stages before anything reads them
        nxt_st.din_meta = input_port_bits;
        nxt_st.din_sync = st_ff.din_meta;
        nxt_st.cfg_meta = input_config_flag;
        nxt_st.cfg_sync = st_ff.cfg_meta;

        // Output byte latches, held until the same byte is rewritten
        if (wr_dio_low) begin
            nxt_st.dout[DAQIO_DATA_W-1:0] = io_wdata;
        end
        if (wr_dio_high) begin
            nxt_st.dout[DAQIO_DIO_W-1:DAQIO_DATA_W] = io_wdata;
        end

        // Only bit 0 and the width bit matter; bits 6-1 are dropped
        if (wr_fifo) begin
            nxt_st.fifo_en   = io_wdata[DAQIO_FIFO_EN_BIT];
            nxt_st.width_sel = io_wdata[DAQIO_WIDTH_BIT];
        end

        // Busy: a new start wins over a done in the same cycle
        if (conv_start) begin
            nxt_st.busy = 1'b1;
        end else if (conv_done) begin
            nxt_st.busy = 1'b0;
        end

        // Channel follows the mux only while idle, so a read
        // during conversion never shows a channel in flux
        if (!nxt_st.busy) begin
            nxt_st.chan = next_channel_number;
        end

        // Data valid: a finishing conversion beats a host clear
        if (conv_done) begin
            nxt_st.valid = 1'b1;
        end else if (wr_status) begin
            nxt_st.valid = 1'b0;
        end

        // Interrupt follows the flag, gated by the control bit
        nxt_st.irq   = nxt_st.valid && irq_gate;
        nxt_st.level = irq_level_select;

        // Read answer: sample now, drive for one cycle, then release
        case (st_ff.rd_state)
            DAQIO_RD_IDLE: begin
                if (io_rd && rd_hit) begin
                    nxt_st.rd_state = DAQIO_RD_ANSWER;
                    nxt_st.rdata    = rd_byte;
                end
            end
            DAQIO_RD_ANSWER: begin
                nxt_st.rd_state = DAQIO_RD_IDLE;
                nxt_st.rdata    = DAQIO_BYTE_RST;
            end
            default: begin
                nxt_st.rd_state = DAQIO_RD_IDLE;
                nxt_st.rdata    = DAQIO_BYTE_RST;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{din_meta:  '0,
                       din_sync:  '0,
                       cfg_meta:  1'b0,
                       cfg_sync:  1'b0,
                       dout:      DAQIO_DOUT_RST,
                       fifo_en:   1'b0,
                       width_sel: 1'b0,
                       busy:      1'b0,
                       valid:     1'b0,
                       chan:      '0,
                       irq:       1'b0,
                       level:     '0,
                       rd_state:  DAQIO_RD_IDLE,
                       rdata:     DAQIO_BYTE_RST};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // D/A double buffer
    // ------------------------------------------------------------
    daqio_dac u_dac (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .bus      (dac_link.dac)
    );

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign io_rdata               = st_ff.rdata;
    assign io_rdata_oe            = (st_ff.rd_state == DAQIO_RD_ANSWER);
    assign output_port_bits       = st_ff.dout;
    assign dac_value_bits         = dac_link.dac_value;
    assign fifo_irq_enable        = st_ff.fifo_en;
    assign converter_width_select = st_ff.width_sel;
    assign irq_req                = st_ff.irq;
    assign irq_level              = st_ff.level;

endmodule

// *** dv/daqio_regs_sva.sv ***
// Port-level assertions for the digital I/O, D/A and status register block
`timescale 1ns/1ps
module daqio_regs_sva
    import daqio_pkg::*;
(
    input wire logic                    core_clk,               // Card clock
    input wire logic                    resetn,                 // Async reset, low
    input wire logic                    ce,                     // Clock enable
    input wire logic [DAQIO_ADDR_W-1:0] io_addr,                // Byte offset
    input wire logic                    io_wr,                  // Write strobe
    input wire logic                    io_rd,                  // Read strobe
    input wire logic [DAQIO_DATA_W-1:0] io_wdata,               // Write byte
    input wire logic [DAQIO_DATA_W-1:0] io_rdata,               // Read byte
    input wire logic                    io_rdata_oe,            // Read driven
    input wire logic [DAQIO_DIO_W-1:0]  output_port_bits,       // Output pins
    input wire logic [DAQIO_DAC_W-1:0]  dac_value_bits,         // D/A word
    input wire logic                    conv_done,              // Result ready
    input wire logic                    irq_gate,               // Interrupt gate
    input wire logic [DAQIO_LVL_W-1:0]  irq_level_select,       // Level code
    input wire logic                    fifo_irq_enable,        // FIFO irq on
    input wire logic                    converter_width_select, // Width bit
    input wire logic                    irq_req,                // Interrupt
    input wire logic [DAQIO_LVL_W-1:0]  irq_level               // Level out
);
    // ------------------------------------------------------------
    // Decoded accesses
    // ------------------------------------------------------------
    wire logic w_acc = ce && io_wr;
    wire logic w03   = w_acc && io_addr == DAQIO_OFF_DIO_LOW;
    wire logic w0b   = w_acc && io_addr == DAQIO_OFF_DIO_HIGH;
    wire logic w04   = w_acc && io_addr == DAQIO_OFF_DAC_LOW;
    wire logic w05   = w_acc && io_addr == DAQIO_OFF_DAC_HIGH;
    wire logic w06   = w_acc && io_addr == DAQIO_OFF_FIFO_IRQ;
    wire logic w08   = w_acc && io_addr == DAQIO_OFF_STATUS;
    wire logic r_new = ce && io_rd && !io_rdata_oe;
    wire logic r_map = io_addr == DAQIO_OFF_DIO_LOW || io_addr == DAQIO_OFF_STATUS
                       || io_addr == DAQIO_OFF_DIO_HIGH;
    // Nibble as written, so the D/A check needs no deep $past
    logic [3:0] nib_ff;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            nib_ff <= 4'h0;
        end else if (w04) begin
            nib_ff <= io_wdata[7:4];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_dac_low;
        w04;
    endsequence
    sequence s_dac_high;
        w05;
    endsequence
    a_read_once:    assert property (r_new && r_map |=> io_rdata_oe ##1 !io_rdata_oe)
        else $error("read answer not exactly one cycle");
    a_read_refused: assert property (r_new && !r_map |=> !io_rdata_oe)
        else $error("unmapped read was answered");
    a_rdata_free:   assert property (!io_rdata_oe |-> io_rdata == 8'h00)
        else $error("read data driven while released");
    a_dout_low:     assert property (w03 |=> output_port_bits[7:0] == $past(io_wdata)
        && output_port_bits[15:8] == $past(output_port_bits[15:8]))
        else $error("output low byte load wrong");
    a_dout_hold:    assert property (!(w03 || w0b) |=> $stable(output_port_bits))
        else $error("output latch changed without write");
    a_dac_held:     assert property (s_dac_low |=> $stable(dac_value_bits))
        else $error("low D/A write moved converter");
    a_dac_update:   assert property (s_dac_high |=>
        dac_value_bits == {$past(io_wdata), nib_ff})
        else $error("D/A word not assembled in one step");
    a_fifo_ctrl:    assert property (w06 |=> fifo_irq_enable == $past(io_wdata[0])
        && converter_width_select == $past(io_wdata[7]))
        else $error("FIFO control bits wrong");
    a_irq_raise:    assert property ((ce && conv_done) ##1
        (ce && irq_gate && !w08) |=> irq_req)
        else $error("interrupt not raised after done");
    a_irq_gated:    assert property (ce && !irq_gate |=> !irq_req)
        else $error("interrupt passed a closed gate");
    a_irq_clear:    assert property ((w08 && !conv_done) ##1
        (ce && !conv_done) |=> !irq_req)
        else $error("interrupt not cleared by status write");
    a_level_copy:   assert property (ce |=> irq_level == $past(irq_level_select))
        else $error("interrupt level not passed on");
endmodule

bind daqio_regs daqio_regs_sva u_sva (.*);

// *** dv/daqio_host.sv ***
// Host software model driving the card's I/O port
`timescale 1ns/1ps
module daqio_host
    import daqio_pkg::*;
(
    input  wire logic                    core_clk, // Card clock
    output logic      [DAQIO_ADDR_W-1:0] io_addr,  // Byte offset
    output logic                         io_wr,    // Write strobe
    output logic                         io_rd,    // Read strobe
    output logic      [DAQIO_DATA_W-1:0] io_wdata  // Write byte
);
    // Idle bus at time zero
    initial begin
        io_addr = 5'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // One write; data goes stale afterwards so nothing leans on it
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge core_clk);
        #2 io_wr = 1'b0;
        io_wdata = ~d;
        // Let one edge pass so a following call never retoggles the strobe
        @(posedge core_clk);
        #2;
    endtask
    // One read plus the idle cycle that reads need between them
    task automatic rd(input logic [4:0] a);
        io_addr = a;
        io_rd = 1'b1;
        @(posedge core_clk);
        #2 io_rd = 1'b0;
        @(posedge core_clk);
        #2;
    endtask
    // Acknowledge data with any value at the status offset
    task automatic clr();
        wr(DAQIO_OFF_STATUS, 8'($urandom()));
    endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the digital I/O, D/A and status register block
`timescale 1ns/1ps
module testbench;
    import daqio_pkg::*;
    logic core_clk = 1'b0, resetn, ce, io_wr, io_rd, io_rdata_oe, conv_start, conv_done;
    logic next_chan_unipolar, input_config_flag, irq_gate, irq_req;
    logic fifo_irq_enable, converter_width_select;
    logic [4:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic [15:0] input_port_bits, output_port_bits, v, w;
    logic [11:0] dac_value_bits, dac_exp;
    logic [3:0] next_channel_number, c0;
    logic [2:0] irq_level_select, irq_level;
    logic [7:0] exp_q[$];
    logic [7:0] ftab[4] = '{8'h81, 8'h7E, 8'h01, 8'h80};
    int mismatches = 0, samples_checked = 0;
    daqio_regs dut (.*);
    daqio_host host (.*);
    always #12.5 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // Shared checks and stimulus helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    task automatic pulse(input bit done);
        if (done) conv_done = 1'b1; else conv_start = 1'b1;
        cyc(1);
        conv_done = 1'b0;
        conv_start = 1'b0;
    endtask
    task results;
        $display("Checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Read answers are matched against the oldest note; a stray one is an error
    always @(posedge core_clk) begin
        if (io_rdata_oe === 1'b1) begin
            if (exp_q.size() == 0) chk(16'(io_rdata), 16'hFFFF, "unexpected read");
            else chk(16'(io_rdata), 16'(exp_q.pop_front()), "read byte");
        end
    end
    // Run is about 126 cycles; the 4000-cycle bound is generous
    initial begin
        #(25 * 4000);
        mismatches++;
        $display("ERROR watchdog expected finish seen hang");
        results;
    end
    initial begin
        {resetn, conv_start, conv_done, next_chan_unipolar, input_config_flag} = 5'b0;
        // Enable and interrupt gate on, every other level input low
        {ce, irq_gate, next_channel_number, irq_level_select, input_port_bits} = 25'h1800000;
        dac_exp = DAQIO_DAC_RST;
        repeat (8) @(posedge core_clk);
        #2 resetn = 1'b1;
        void'($urandom(32'h14A062BE));
        chk(output_port_bits, DAQIO_DOUT_RST, "dout reset");
        // Digital lines: live reads, write-only latches, ce low ignored
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom());
            input_port_bits = v;
            cyc(4);
            rchk(DAQIO_OFF_DIO_LOW, v[7:0]);
            rchk(DAQIO_OFF_DIO_HIGH, v[15:8]);
            input_port_bits = ~v;
            cyc(3);
            rchk(DAQIO_OFF_DIO_LOW, ~v[7:0]);
            w = 16'($urandom());
            host.wr(DAQIO_OFF_DIO_LOW, w[7:0]);
            host.wr(DAQIO_OFF_DIO_HIGH, w[15:8]);
            chk(output_port_bits, w, "dout");
            rchk(DAQIO_OFF_DIO_HIGH, ~v[15:8]);
            ce = 1'b0;
            host.wr(DAQIO_OFF_DIO_LOW, ~w[7:0]);
            ce = 1'b1;
            chk(output_port_bits, w, "dout hold");
        end
        $display("digital line test done");
        // D/A: low byte first, junk in its low nibble, converter moves once
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom());
            host.wr(DAQIO_OFF_DAC_LOW, {v[3:0], 4'($urandom())});
            chk(16'(dac_value_bits), 16'(dac_exp), "dac held");
            host.wr(DAQIO_OFF_DAC_HIGH, v[11:4]);
            dac_exp = v[11:0];
            chk(16'(dac_value_bits), 16'(dac_exp), "dac word");
        end
        $display("dac test done");
        foreach (ftab[i]) begin
            host.wr(DAQIO_OFF_FIFO_IRQ, ftab[i]);
            chk(16'({converter_width_select, fifo_irq_enable}),
                16'({ftab[i][7], ftab[i][0]}), "fifo ctrl");
        end
        $display("fifo control test done");
        // Status: idle fields, busy freeze, done, clear, gate
        next_channel_number = 4'($urandom());
        irq_level_select = 3'($urandom());
        {next_chan_unipolar, input_config_flag} = 2'b11;
        cyc(3);
        chk(16'(irq_level), 16'(irq_level_select), "irq level");
        rchk(DAQIO_OFF_STATUS, {4'b0110, next_channel_number});
        next_chan_unipolar = 1'b0;
        rchk(DAQIO_OFF_STATUS, {4'b0010, next_channel_number});
        pulse(1'b0);
        c0 = next_channel_number;
        next_channel_number = c0 + 4'h1;
        rchk(DAQIO_OFF_STATUS, {4'b1010, c0});
        pulse(1'b1);
        cyc(1);
        chk(16'(irq_req), 16'h0001, "irq raised");
        rchk(DAQIO_OFF_STATUS, {4'b0011, next_channel_number});
        host.clr();
        cyc(1);
        chk(16'(irq_req), 16'h0000, "irq cleared");
        rchk(DAQIO_OFF_STATUS, {4'b0010, next_channel_number});
        pulse(1'b1);
        irq_gate = 1'b0;
        cyc(2);
        chk(16'(irq_req), 16'h0000, "irq gated");
        host.clr();
        input_config_flag = 1'b0;
        cyc(3);
        rchk(DAQIO_OFF_STATUS, {4'b0000, next_channel_number});
        host.rd(5'h02);
        host.rd(DAQIO_OFF_FIFO_IRQ);
        cyc(2);
        chk(16'(exp_q.size()), 16'h0000, "reads pending");
        $display("status test done");
        results;
    end
endmodule
